// >>> core/fwsq_pkg.sv
// package: constants for the flash status poller host controller
package fwsq_pkg;
  // ****************************************************************
  // apb register map of the controller
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // ctrl bit positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_BYTE_BIT = 3;
  // op codes
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_POLL  = 2'h2;
  localparam logic [1:0] OP_QUERY = 2'h3;
  // status bit positions
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_FAIL_BIT    = 2;
  localparam int ST_RDYBSY_BIT  = 3;
  localparam int ST_WINDOW_BIT  = 4;
  localparam int ST_SUSP_BIT    = 5;
  // ****************************************************************
  // status bit positions on the flash data bus
  // ****************************************************************
  localparam int POLL_BIT_POS    = 7;
  localparam int TOGGLE1_POS     = 6;
  localparam int TIME_LIMIT_POS  = 5;
  localparam int ERASE_WIN_POS   = 3;
  localparam int TOGGLE2_POS     = 2;
  // ****************************************************************
  // query table word addresses and expected answers
  // ****************************************************************
  localparam logic [7:0]  QRY_WRITE_TO_ADDR = 8'h1F;
  localparam logic [15:0] QRY_WRITE_TO_VAL  = 16'h0004;
  localparam logic [7:0]  QRY_ERASE_TO_ADDR = 8'h21;
  localparam logic [15:0] QRY_ERASE_TO_VAL  = 16'h000A;
  localparam logic [7:0]  QRY_IFACE_ADDR    = 8'h28;
  localparam logic [15:0] QRY_IFACE_VAL     = 16'h0002;
  localparam logic [7:0]  QRY_REGIONS_ADDR  = 8'h2C;
  localparam logic [15:0] QRY_REGIONS_VAL   = 16'h0002;
  localparam logic [7:0]  QRY_BOOT_ADDR     = 8'h4F;
  localparam logic [15:0] QRY_BOOT_BOTTOM   = 16'h0002;
  localparam logic [15:0] QRY_BOOT_TOP      = 16'h0003;
  // ****************************************************************
  // bus cycle timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int ACCESS_NS       = 90;
  localparam int ACCESS_CYC      = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int STROBE_NS       = 50;
  localparam int STROBE_CYC      = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int RECOVER_NS      = 30;
  localparam int RECOVER_CYC     = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // bus cycle states, gray from IDLE to EVAL; EVAL back to IDLE changes two bits
  typedef enum logic [2:0] {
    FWSQ_IDLE  = 3'b000,
    FWSQ_SETUP = 3'b001,
    FWSQ_STRB  = 3'b011,
    FWSQ_HOLD  = 3'b010,
    FWSQ_EVAL  = 3'b110
  } fwsq_state_t;
endpackage : fwsq_pkg

// >>> core/fwsq_sync.sv
// file: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fwsq_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a bit changes only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : fwsq_sync

// >>> core/fwsq_host.sv
// file: host controller that drives the flash pins and polls its status
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: device shows inverted datum bit seven on poll bit while programming.
// RULE_02: host polls program status at the very address being programmed.
// RULE_03: protected program target shows poll status about 1 us, then array.
// RULE_04: poll bit reads 0 during erase, 1 when done or suspended.
// RULE_05: all-protected erase shows poll status about 100 us, then array.
// RULE_06: host polls erase status at an address inside a selected sector.
// RULE_07: after poll bit turns true, host reads again before trusting data.
// RULE_08: toggle bit one flips on each read during program or erase.
// RULE_09: all-protected erase toggles toggle bit one for 100 us.
// RULE_10: protected program address toggles toggle bit one for about 2 us.
// RULE_11: toggle bit one stops flipping once erase suspend is entered.
// RULE_12: toggle bit one flips during program inside erase suspend.
// RULE_13: toggle bit two flips only in sectors selected for erase.
// RULE_14: suspended sector reads poll 1, bit one steady, bit two flipping.
// RULE_15: toggle bit two is valid after the final command strobe rises.
// RULE_16: host reads twice, compares toggle bit; unchanged means complete.
// RULE_17: query word 1F returns 0004, word 21 returns 000A.
// RULE_18: query word 28 returns 0002; byte address is twice word address.
// RULE_19: query word 2C reports 0002 erase block regions.
// RULE_20: query word 4F returns 02h bottom boot or 03h top boot.
// RULE_21: time-limit flag set to one means the operation failed; host fails only if the flag stands on two reads and bit one still flips.
// RULE_22: erase-window flag low until time-out expires, high once erasing.
// RULE_23: ready/busy output low while programming or erasing, else high.
// RULE_24: toggling means inversion between each pair of consecutive reads.
module fwsq_host #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic      [AW-1:0] flash_addr,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic               flash_byte_n,
  input  wire logic [DW-1:0] flash_dq_in,
  output logic      [DW-1:0] flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic          ready_busy_out
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [1:0]    op_q;
  logic          byte_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] prev_q;
  logic          have_prev_q;
  logic          busy_q;
  logic          done_q;
  logic          fail_q;
  logic          susp_q;
  logic          win_q;
  logic          go;
  fwsq_pkg::fwsq_state_t state_q;
  logic [7:0]    cnt_q;
  logic [DW-1:0] dq_s;
  logic          rb_s;
  logic [DW-1:0] sample;
  logic          verdict;
  logic          timeout_seen;
  fwsq_sync #(.W(DW + 1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({ready_busy_out, flash_dq_in}),
    .dout    ({rb_s, dq_s})
  );
  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign go = psel && penable && pwrite && !busy_q
              && paddr == fwsq_pkg::REG_CTRL
              && pwdata[fwsq_pkg::CTRL_GO_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q    <= fwsq_pkg::OP_READ;
      byte_q  <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (psel && penable && pwrite && !busy_q) begin
      if (paddr == fwsq_pkg::REG_CTRL) begin
        op_q   <= pwdata[fwsq_pkg::CTRL_OP_LSB +: 2];
        byte_q <= pwdata[fwsq_pkg::CTRL_BYTE_BIT];
      end else if (paddr == fwsq_pkg::REG_ADDR) begin
        addr_q <= pwdata[AW-1:0];
      end else if (paddr == fwsq_pkg::REG_WDATA) begin
        wdata_q <= pwdata[DW-1:0];
      end
    end
  end
  always_comb begin
    prdata = fwsq_pkg::RESET_ZERO;
    if (paddr == fwsq_pkg::REG_CTRL) begin
      prdata[fwsq_pkg::CTRL_OP_LSB +: 2] = op_q;
      prdata[fwsq_pkg::CTRL_BYTE_BIT]    = byte_q;
    end else if (paddr == fwsq_pkg::REG_ADDR) begin
      prdata[AW-1:0] = addr_q;
    end else if (paddr == fwsq_pkg::REG_WDATA) begin
      prdata[DW-1:0] = wdata_q;
    end else if (paddr == fwsq_pkg::REG_STATUS) begin
      prdata[fwsq_pkg::ST_BUSY_BIT]   = busy_q;
      prdata[fwsq_pkg::ST_DONE_BIT]   = done_q;
      prdata[fwsq_pkg::ST_FAIL_BIT]   = fail_q;
      prdata[fwsq_pkg::ST_RDYBSY_BIT] = rb_s;       // [RULE_23]
      prdata[fwsq_pkg::ST_WINDOW_BIT] = win_q;
      prdata[fwsq_pkg::ST_SUSP_BIT]   = susp_q;
    end else if (paddr == fwsq_pkg::REG_RDATA) begin
      prdata[DW-1:0] = rdata_q;
    end
  end
  // ****************************************************************
  // flash bus cycle sequencer
  // ****************************************************************
  assign sample = dq_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fwsq_pkg::FWSQ_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        fwsq_pkg::FWSQ_IDLE: begin
          if (go) begin
            state_q <= fwsq_pkg::FWSQ_SETUP;
          end
        end
        fwsq_pkg::FWSQ_SETUP: begin
          state_q <= fwsq_pkg::FWSQ_STRB;
          cnt_q   <= (op_q == fwsq_pkg::OP_WRITE)
                     ? 8'(fwsq_pkg::STROBE_CYC)
                     : 8'(fwsq_pkg::ACCESS_CYC + 4);
        end
        fwsq_pkg::FWSQ_STRB: begin
          if (cnt_q == 8'h00) begin
            state_q <= fwsq_pkg::FWSQ_HOLD;
            cnt_q   <= 8'(fwsq_pkg::RECOVER_CYC);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fwsq_pkg::FWSQ_HOLD: begin
          if (cnt_q == 8'h00) begin
            state_q <= fwsq_pkg::FWSQ_EVAL;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fwsq_pkg::FWSQ_EVAL: begin
          // a poll with no verdict yet issues another read cycle
          if (op_q == fwsq_pkg::OP_POLL && busy_q && !verdict
              && !timeout_seen) begin
            state_q <= fwsq_pkg::FWSQ_SETUP;
          end else begin
            state_q <= fwsq_pkg::FWSQ_IDLE;
          end
        end
        default: state_q <= fwsq_pkg::FWSQ_IDLE;
      endcase
    end
  end
  // pin drive; query uses word address, doubled when in byte mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr   <= '0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_byte_n <= 1'b1;
      flash_dq_out <= '0;
      flash_dq_oe  <= 1'b0;
    end else begin
      flash_byte_n <= !byte_q;
      if (state_q == fwsq_pkg::FWSQ_SETUP) begin
        flash_addr <= (op_q == fwsq_pkg::OP_QUERY && byte_q)
                      ? {addr_q[AW-2:0], 1'b0} : addr_q; // [RULE_18]
        flash_ce_n   <= 1'b0;
        flash_dq_out <= wdata_q;
        flash_dq_oe  <= (op_q == fwsq_pkg::OP_WRITE);
        flash_oe_n   <= (op_q == fwsq_pkg::OP_WRITE);
        flash_we_n   <= (op_q != fwsq_pkg::OP_WRITE);
      end else if (state_q == fwsq_pkg::FWSQ_STRB && cnt_q == 8'h00) begin
        // strobes rise together; oe release gives each poll a new cycle
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;                                    // [RULE_15]
      end else if (state_q == fwsq_pkg::FWSQ_HOLD && cnt_q == 8'h00) begin
        flash_dq_oe <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // read capture and status evaluation
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q     <= '0;
      prev_q      <= '0;
      have_prev_q <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      susp_q      <= 1'b0;
      win_q       <= 1'b0;
    end else if (go) begin
      busy_q      <= 1'b1;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      susp_q      <= 1'b0;
      have_prev_q <= 1'b0;
    end else if (state_q == fwsq_pkg::FWSQ_STRB && cnt_q == 8'h00
                 && op_q != fwsq_pkg::OP_WRITE) begin
      rdata_q <= sample;
      // the address held for polling is the programmed or erased one
      if (op_q == fwsq_pkg::OP_POLL) begin                  // [RULE_02] [RULE_06]
        win_q       <= sample[fwsq_pkg::ERASE_WIN_POS];     // [RULE_22]
        prev_q      <= sample;
        have_prev_q <= 1'b1;
      end
    end else if (state_q == fwsq_pkg::FWSQ_EVAL) begin
      if (op_q != fwsq_pkg::OP_POLL) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (verdict || timeout_seen) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        fail_q <= timeout_seen;                             // [RULE_21]
      end
    end
  end
  // toggle comparison over two consecutive reads
  logic [DW-1:0] last_q;
  logic          last_ok_q;
  logic          settle_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q    <= '0;
      last_ok_q <= 1'b0;
      settle_q  <= 1'b0;
    end else if (go) begin
      last_ok_q <= 1'b0;
      settle_q  <= 1'b0;
    end else if (state_q == fwsq_pkg::FWSQ_EVAL
                 && op_q == fwsq_pkg::OP_POLL) begin
      last_q    <= rdata_q;
      last_ok_q <= 1'b1;
      if (last_ok_q && rdata_q[fwsq_pkg::TOGGLE1_POS]
          == last_q[fwsq_pkg::TOGGLE1_POS]) begin           // [RULE_16] [RULE_24]
        // bit one steady: settled, done on the next read; bit two is not examined and susp_q stays 0
        settle_q <= 1'b1;                                   // [RULE_07]
      end
    end
  end
  // verdict, taken one read after the toggle stopped
  assign verdict = state_q == fwsq_pkg::FWSQ_EVAL
                   && op_q == fwsq_pkg::OP_POLL && settle_q;
  // fail only when the limit flag stands on two reads and bit one flips
  assign timeout_seen = state_q == fwsq_pkg::FWSQ_EVAL
                        && op_q == fwsq_pkg::OP_POLL && last_ok_q
                        && rdata_q[fwsq_pkg::TIME_LIMIT_POS]
                        && last_q[fwsq_pkg::TIME_LIMIT_POS]
                        && rdata_q[fwsq_pkg::TOGGLE1_POS]
                           != last_q[fwsq_pkg::TOGGLE1_POS];
endmodule : fwsq_host

// >>> sim/fwsq_monitor.sv
// monitor: flash bus and apb checks on the host controller ports
`timescale 1ns/1ps
module fwsq_monitor #(
  parameter int AW = 22
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_ce_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_we_n,
  input wire logic          flash_dq_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_zero_wait; psel && penable |-> pready; endproperty
  property p_no_fight; !flash_oe_n |-> !flash_dq_oe; endproperty
  property p_one_strobe; !(!flash_oe_n && !flash_we_n); endproperty
  property p_we_sel; !flash_we_n |-> !flash_ce_n; endproperty
  property p_oe_sel; !flash_oe_n |-> !flash_ce_n; endproperty
  property p_we_width;
    $fell(flash_we_n) |-> !flash_ce_n throughout (!flash_we_n [*8]);
  endproperty
  property p_oe_width; $fell(flash_oe_n) |-> !flash_oe_n [*8]; endproperty
  property p_addr_hold;
    !flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr);
  endproperty
  // ****************************************************************
  // assertions and covers
  // ****************************************************************
  a_zero_wait: assert property (p_zero_wait)
    else $error("pready low in access phase");
  a_no_fight: assert property (p_no_fight)
    else $error("data driven during read");
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobes together");
  a_we_sel: assert property (p_we_sel)
    else $error("write strobe without chip select");
  a_oe_sel: assert property (p_oe_sel)
    else $error("read strobe without chip select");
  a_we_width: assert property (p_we_width)
    else $error("write strobe too short");
  a_oe_width: assert property (p_oe_width)
    else $error("read strobe too short");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during read");
  c_write: cover property ($rose(flash_we_n));
  c_read: cover property ($rose(flash_oe_n));
  c_apb: cover property (psel && penable && pready);
endmodule : fwsq_monitor

// >>> sim/fwsq_flash_model.sv
// flash model: array, status bits while busy, query table
`timescale 1ns/1ps
module fwsq_flash_model #(
  parameter int          AW   = 22,
  parameter int          DW   = 16,
  parameter int          BUSY = 4,
  parameter logic [15:0] BOOT = 16'h0002
) (
  input  wire logic [AW-1:0] flash_addr,
  input  wire logic          flash_ce_n,
  input  wire logic          flash_oe_n,
  input  wire logic          flash_we_n,
  input  wire logic          flash_byte_n,
  input  wire logic [DW-1:0] flash_dq_out,
  output logic      [DW-1:0] flash_dq_in,
  output logic               ready_busy_out
);
  logic [DW-1:0] mem_q [logic [AW-1:0]];
  logic [DW-1:0] pdat_q = '0;
  logic [DW-1:0] last_q = '0;
  logic [DW-1:0] st;
  logic [AW-1:0] padr_q = '0;
  logic          arm_q = 1'b0;
  logic          ers_q = 1'b0;
  logic          qry_q = 1'b0;
  logic          tg1_q = 1'b0;
  logic          tg2_q = 1'b0;
  logic [7:0]    qa;
  int            left_q = 0;
  logic          wr_act;
  logic          rd_act;
  // a cycle ends when the first of the two strobes rises
  assign wr_act = !flash_we_n && !flash_ce_n;
  assign rd_act = !flash_oe_n && !flash_ce_n;
  // ****************************************************************
  // commands taken on the rising write strobe
  // ****************************************************************
  always @(negedge wr_act) begin
    if (arm_q) begin
      mem_q[flash_addr] = flash_dq_out;
      pdat_q = flash_dq_out;
      padr_q = flash_addr;
      left_q = BUSY;
      ers_q = 1'b0;
      arm_q = 1'b0;
    end else begin
      case (flash_dq_out[7:0])
        8'hA0: arm_q = 1'b1;
        8'h98: qry_q = 1'b1;
        8'hF0: qry_q = 1'b0;
        8'h30: begin
          mem_q.delete();
          padr_q = flash_addr;
          left_q = BUSY;
          ers_q = 1'b1;
        end
        default: ;
      endcase
    end
  end
  // each completed read while busy advances toggle bit one, and toggle bit two in the erased sector
  always @(negedge rd_act) begin
    last_q = st;
    if (left_q > 0) begin
      left_q--;
      tg1_q = ~tg1_q;
      if (ers_q && flash_addr[AW-1:15] == padr_q[AW-1:15])
        tg2_q = ~tg2_q;
    end
  end
  always @* begin
    qa = flash_byte_n ? flash_addr[7:0] : flash_addr[8:1];
    st = mem_q.exists(flash_addr) ? mem_q[flash_addr] : '1;
    if (qry_q) begin
      case (qa)
        8'h1F: st = 16'h0004;
        8'h21: st = 16'h000A;
        8'h28: st = 16'h0002;
        8'h2C: st = 16'h0002;
        8'h4F: st = BOOT;
        default: st = '0;
      endcase
    end else if (left_q > 0) begin
      st = '0;
      // poll bit is wrong unless read at the programmed word
      st[7] = ers_q ? 1'b0 : ~pdat_q[7] ^ (flash_addr != padr_q);
      st[6] = tg1_q;
      st[3] = ers_q;
      st[2] = tg2_q;
    end
    // deselected bus shows the inverse of the last value
    flash_dq_in = (!flash_ce_n && !flash_oe_n) ? st : ~last_q;
  end
  assign ready_busy_out = (left_q == 0);
endmodule : fwsq_flash_model

// >>> sim/testbench.sv
// testbench: apb scenarios on the host controller with a flash model
`timescale 1ns/1ps
module testbench;
  localparam int AW = 22;
  localparam int DW = 16;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err, flash_ce_n, flash_oe_n, flash_we_n;
  logic          flash_byte_n, flash_dq_oe, ready_busy_out;
  logic [AW-1:0] flash_addr;
  logic [DW-1:0] flash_dq_in, flash_dq_out;
  int            error_cnt = 0;
  int            tests_run = 0;
  always #2.5 pclk = ~pclk;
  fwsq_host #(.AW(AW), .DW(DW)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .ready_busy_out(ready_busy_out)
  );
  fwsq_flash_model #(.AW(AW), .DW(DW)) u_flash (
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_byte_n(flash_byte_n), .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb
  // starts one controller operation and waits for it to finish
  task automatic run_op(input logic [1:0] op, input logic [31:0] a, d);
    int n;
    n = 0;
    apb(1'b1, fwsq_pkg::REG_ADDR, a);
    apb(1'b1, fwsq_pkg::REG_WDATA, d);
    apb(1'b1, fwsq_pkg::REG_CTRL, {28'h0, 1'b0, op, 1'b1});
    do begin
      apb(1'b0, fwsq_pkg::REG_STATUS, 32'h0);
      n++;
    end while ((rd[fwsq_pkg::ST_BUSY_BIT] !== 1'b0
                || rd[fwsq_pkg::ST_DONE_BIT] !== 1'b1) && n < 2000);
    if (n >= 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : run_op
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_reset;
    apb(1'b0, fwsq_pkg::REG_STATUS, 32'h0);
    check(rd[fwsq_pkg::ST_BUSY_BIT], 1'b0);
    check(rd[fwsq_pkg::ST_RDYBSY_BIT], 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b0);
    check(rd, 32'h0000_0000);
  endtask : s_reset
  task automatic s_program(input logic [31:0] a, input logic [15:0] d);
    run_op(fwsq_pkg::OP_WRITE, a, 32'h0000_00A0);
    run_op(fwsq_pkg::OP_WRITE, a, {16'h0, d});
    run_op(fwsq_pkg::OP_POLL, a, 32'h0);
    check(rd[fwsq_pkg::ST_FAIL_BIT], 1'b0);
    run_op(fwsq_pkg::OP_READ, a, 32'h0);
    apb(1'b0, fwsq_pkg::REG_RDATA, 32'h0);
    check(rd[15:0], d);
  endtask : s_program
  task automatic s_query;
    logic [7:0]  qa [5];
    logic [15:0] qv [5];
    qa = '{fwsq_pkg::QRY_WRITE_TO_ADDR, fwsq_pkg::QRY_ERASE_TO_ADDR,
           fwsq_pkg::QRY_IFACE_ADDR, fwsq_pkg::QRY_REGIONS_ADDR,
           fwsq_pkg::QRY_BOOT_ADDR};
    qv = '{fwsq_pkg::QRY_WRITE_TO_VAL, fwsq_pkg::QRY_ERASE_TO_VAL,
           fwsq_pkg::QRY_IFACE_VAL, fwsq_pkg::QRY_REGIONS_VAL,
           fwsq_pkg::QRY_BOOT_BOTTOM};
    run_op(fwsq_pkg::OP_WRITE, 32'h0000_0055, 32'h0000_0098);
    for (int i = 0; i < 5; i++) begin
      run_op(fwsq_pkg::OP_QUERY, {24'h0, qa[i]}, 32'h0);
      apb(1'b0, fwsq_pkg::REG_RDATA, 32'h0);
      check(rd[15:0], qv[i]);
    end
    run_op(fwsq_pkg::OP_WRITE, 32'h0000_0000, 32'h0000_00F0);
  endtask : s_query
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    s_reset();
    s_program(32'h0000_0123, 16'h5A3C);
    s_program(32'h0000_0124, 16'h00C3);
    s_query();
    tally_and_finish();
  end
endmodule : testbench
bind fwsq_host fwsq_monitor #(.AW(AW)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_oe(flash_dq_oe)
);
